//--- rtl/jesd_link_control_regs.sv
// Link control register bank with sync request, multiframe counter and timestamp insertion.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps

// Overview of operation
// - Timestamp enable puts mark on sample LSB.
// - Mark and sample share identical pipeline delay.
// - Wider field: mark below converter LSB.
// - Alignment sequence always reports zero control bits.
// - Link enable resets to one; writable.
// - Disabled: reset link, power down, gate clocks.
// - Disabled: counter held, SYSREF ignored.
// - Frames register holds K-1, resets 31.
// - 64B/66B modes use K = 256*E/F.
// - Sync bit resets one; zero requests sync.
// - Software request combines with selected pin.
// - Pin low holds request; source 2 releases.
// - Source 0 pin, 1 diff input, 2 none.
module jesd_link_control_regs #(
  parameter int CONV_W = 9,
  parameter int LINK_W = 12
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Register port.
  input  wire logic [11:0]       addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  // Mode decoder and transport timing, same clock.
  input  wire logic              mode_is_64b66b,
  input  wire logic [7:0]        mode_e,
  input  wire logic [7:0]        mode_f,
  input  wire logic              frame_tick,
  // Asynchronous pins.
  input  wire logic              single_ended_sync_pin,
  input  wire logic              timestamp_diff_input,
  input  wire logic              sysref_pin,
  // Sample path, same clock.
  input  wire logic [CONV_W-1:0] sample_in,
  input  wire logic              sample_valid_in,
  input  wire logic              timestamp_mark,
  output logic      [LINK_W-1:0] sample_out,
  output logic                   sample_valid_out,
  // Link control.
  output logic                   link_reset_n,
  output logic                   serializer_power_down,
  output logic                   link_clock_enable,
  output logic                   link_restart,
  output logic                   sync_request,
  output logic                   timestamp_receiver_enable,
  output logic      [5:0]        link_output_mode,
  output logic      [8:0]        frames_per_multiframe_last,
  output logic      [8:0]        multiframe_count,
  output logic                   multiframe_boundary,
  output logic      [1:0]        ila_control_bits
);

  localparam int PAD_W = LINK_W - CONV_W;

  typedef struct packed {
    logic                      ts_en;
    logic                      link_en;
    logic [5:0]                mode;
    logic [7:0]                km1;
    logic                      sw_sync_n;
    logic [1:0]                sync_sel;
    logic                      ts_recv_en;
    logic [7:0]                rdata;
    jesd_link_pkg::link_state_e link_state;
    logic [2:0]                se_sync;
    logic [2:0]                td_sync;
    logic [2:0]                sr_sync;
    logic                      se_lvl;
    logic                      td_lvl;
    logic                      sr_lvl;
    logic                      link_rst_n;
    logic                      ser_pd;
    logic                      clk_en;
    logic                      restart;
    logic                      sync_req;
    logic [8:0]                k_last;
    logic [8:0]                mf_cnt;
    logic                      mf_edge;
    logic [LINK_W-1:0]         samp;
    logic                      samp_vld;
    logic [1:0]                ila_cs;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Last frame index of a multiframe; a zero F falls back to the register so the divide never sees zero.
  function automatic logic [8:0] k_last_f(input logic is64, input logic [7:0] e, input logic [7:0] f,
                                          input logic [7:0] km1);
    logic [16:0] k;
    k = 17'h00000;
    if (is64 && (f != 8'h00)) begin
      k = (jesd_link_pkg::K_64B_MULT * {9'h000, e}) / {9'h000, f};
      return 9'(k - 17'h00001);
    end
    return {1'b0, km1};
  endfunction

  // Filtered level of a three-stage synchroniser: moves only when stages two and three agree.
  function automatic logic filt_f(input logic [2:0] chain, input logic lvl);
    return (chain[2] == chain[1]) ? chain[2] : lvl;
  endfunction

  always_comb begin
    logic sysref_rise;
    logic pin_hold;
    sysref_rise = 1'b0;
    pin_hold    = 1'b0;
    state_next  = state_reg;
    state_next.rdata   = 8'h00;
    state_next.restart = 1'b0;
    state_next.mf_edge = 1'b0;

    if (wr) begin
      unique case (addr)
        jesd_link_pkg::TS_LSB_CTRL_ADDR: state_next.ts_en   = wdata[jesd_link_pkg::TS_EN_BIT];
        jesd_link_pkg::LINK_EN_ADDR:     state_next.link_en = wdata[jesd_link_pkg::LINK_EN_BIT];
        jesd_link_pkg::OUT_MODE_ADDR:    state_next.mode    = wdata[jesd_link_pkg::OUT_MODE_MSB:0];
        jesd_link_pkg::KM1_ADDR:         state_next.km1     = wdata;
        jesd_link_pkg::SW_SYNC_ADDR:     state_next.sw_sync_n = wdata[jesd_link_pkg::SW_SYNC_BIT];
        jesd_link_pkg::SYNC_SRC_ADDR: begin
          state_next.sync_sel   = wdata[jesd_link_pkg::SYNC_SEL_MSB:jesd_link_pkg::SYNC_SEL_LSB];
          state_next.ts_recv_en = wdata[jesd_link_pkg::TS_RECV_BIT];
        end
        default: ;
      endcase
    end

    // Reserved bits and unmapped addresses read as zero.
    if (rd) begin
      unique case (addr)
        jesd_link_pkg::TS_LSB_CTRL_ADDR: state_next.rdata[jesd_link_pkg::TS_EN_BIT]   = state_reg.ts_en;
        jesd_link_pkg::LINK_EN_ADDR:     state_next.rdata[jesd_link_pkg::LINK_EN_BIT] = state_reg.link_en;
        jesd_link_pkg::OUT_MODE_ADDR:    state_next.rdata[jesd_link_pkg::OUT_MODE_MSB:0] = state_reg.mode;
        jesd_link_pkg::KM1_ADDR:         state_next.rdata = state_reg.km1;
        jesd_link_pkg::SW_SYNC_ADDR:     state_next.rdata[jesd_link_pkg::SW_SYNC_BIT] = state_reg.sw_sync_n;
        jesd_link_pkg::SYNC_SRC_ADDR: begin
          state_next.rdata[jesd_link_pkg::SYNC_SEL_MSB:jesd_link_pkg::SYNC_SEL_LSB] = state_reg.sync_sel;
          state_next.rdata[jesd_link_pkg::TS_RECV_BIT] = state_reg.ts_recv_en;
        end
        jesd_link_pkg::LINK_STATUS_ADDR: begin
          state_next.rdata[jesd_link_pkg::STAT_LINK_ON_BIT] = (state_reg.link_state == jesd_link_pkg::LINK_ON);
          state_next.rdata[jesd_link_pkg::STAT_SYNC_BIT]    = state_reg.sync_req;
        end
        default: ;
      endcase
    end

    state_next.se_sync = {state_reg.se_sync[1:0], single_ended_sync_pin};
    state_next.td_sync = {state_reg.td_sync[1:0], timestamp_diff_input};
    state_next.sr_sync = {state_reg.sr_sync[1:0], sysref_pin};
    state_next.se_lvl  = filt_f(state_reg.se_sync, state_reg.se_lvl);
    state_next.td_lvl  = filt_f(state_reg.td_sync, state_reg.td_lvl);
    state_next.sr_lvl  = filt_f(state_reg.sr_sync, state_reg.sr_lvl);
    sysref_rise = state_next.sr_lvl && !state_reg.sr_lvl;

    // A low pin only counts for the source that selects it; source 2 and the unused code 3 see no pin.
    unique case (state_reg.sync_sel)
      jesd_link_pkg::SYNC_SRC_SE: pin_hold = !state_reg.se_lvl;
      jesd_link_pkg::SYNC_SRC_TD: pin_hold = !state_reg.td_lvl;
      default:                    pin_hold = 1'b0;
    endcase
    state_next.sync_req = !state_reg.sw_sync_n || pin_hold;

    state_next.link_rst_n = state_reg.link_en;
    state_next.ser_pd     = !state_reg.link_en;
    state_next.clk_en     = state_reg.link_en;
    state_next.k_last = k_last_f(mode_is_64b66b, mode_e, mode_f, state_reg.km1);

    unique case (state_reg.link_state)
      jesd_link_pkg::LINK_OFF: begin
        state_next.mf_cnt = 9'h000;
        if (state_reg.link_en) begin
          state_next.link_state = jesd_link_pkg::LINK_ON;
          state_next.restart    = 1'b1;
        end
      end
      jesd_link_pkg::LINK_ON: begin
        if (!state_reg.link_en) begin
          state_next.link_state = jesd_link_pkg::LINK_OFF;
          state_next.mf_cnt     = 9'h000;
        end else if (sysref_rise) begin
          state_next.mf_cnt  = 9'h000;
          state_next.mf_edge = 1'b1;
        end else if (frame_tick) begin
          if (state_reg.mf_cnt >= state_reg.k_last) begin
            state_next.mf_cnt  = 9'h000;
            state_next.mf_edge = 1'b1;
          end else begin
            state_next.mf_cnt = state_reg.mf_cnt + 9'h001;
          end
        end
      end
    endcase

    // Sample and mark pass one shared stage, so the mark keeps its sample's latency.
    state_next.samp = LINK_W'(sample_in) << PAD_W;
    if (state_reg.ts_en) begin
      state_next.samp[0] = timestamp_mark;
    end
    state_next.samp_vld = sample_valid_in;
    state_next.ila_cs   = jesd_link_pkg::ILA_CS_VALUE;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{
        ts_en:      jesd_link_pkg::TS_EN_RST,
        link_en:    jesd_link_pkg::LINK_EN_RST,
        mode:       jesd_link_pkg::OUT_MODE_RST,
        km1:        jesd_link_pkg::KM1_RST,
        sw_sync_n:  jesd_link_pkg::SW_SYNC_RST,
        sync_sel:   jesd_link_pkg::SYNC_SEL_RST,
        ts_recv_en: jesd_link_pkg::TS_RECV_RST,
        link_state: jesd_link_pkg::LINK_OFF,
        se_sync:    3'h7,
        td_sync:    3'h7,
        se_lvl:     1'b1,
        td_lvl:     1'b1,
        k_last:     {1'b0, jesd_link_pkg::KM1_RST},
        ser_pd:     1'b1,
        default:    '0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata                      = state_reg.rdata;
  assign sample_out                 = state_reg.samp;
  assign sample_valid_out           = state_reg.samp_vld;
  assign link_reset_n               = state_reg.link_rst_n;
  assign serializer_power_down      = state_reg.ser_pd;
  assign link_clock_enable          = state_reg.clk_en;
  assign link_restart               = state_reg.restart;
  assign sync_request               = state_reg.sync_req;
  assign timestamp_receiver_enable  = state_reg.ts_recv_en;
  assign link_output_mode           = state_reg.mode;
  assign frames_per_multiframe_last = state_reg.k_last;
  assign multiframe_count           = state_reg.mf_cnt;
  assign multiframe_boundary        = state_reg.mf_edge;
  assign ila_control_bits           = state_reg.ila_cs;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ts_lsb_insert_a: assert property (state_reg.ts_en |=> sample_out[0] == $past(timestamp_mark))
    else $error("timestamp mark missing from sample LSB");
  ts_latency_a: assert property (sample_valid_in |=> sample_valid_out)
    else $error("sample valid not delayed by one stage");
  conv_bits_kept_a: assert property (1'b1 |=> sample_out[LINK_W-1:PAD_W] == $past(sample_in))
    else $error("converter bits disturbed by mark");
  ila_cs_zero_a: assert property (ila_control_bits == 2'h0)
    else $error("alignment sequence reports control bits");
  link_enable_wr_a: assert property (wr && addr == jesd_link_pkg::LINK_EN_ADDR |=> ##1
                                     link_reset_n == $past(wdata[0], 2))
    else $error("link enable write not reflected on link reset");
  disabled_hold_a: assert property (!state_reg.link_en ##1 !state_reg.link_en |->
                                    !link_reset_n && serializer_power_down && !link_clock_enable)
    else $error("disabled link not held in reset");
  counter_hold_a: assert property (!state_reg.link_en |=> multiframe_count == 9'h000 && !multiframe_boundary)
    else $error("multiframe counter moved while disabled");
  k_64b_a: assert property (mode_is_64b66b && mode_f == 8'h01 && mode_e == 8'h01 |=>
                            frames_per_multiframe_last == 9'h0ff)
    else $error("effective K wrong in 64B/66B mode");
  sw_sync_req_a: assert property (wr && addr == jesd_link_pkg::SW_SYNC_ADDR && !wdata[0] |=> ##1 sync_request)
    else $error("software sync request not raised");
  source_release_a: assert property (state_reg.sync_sel == jesd_link_pkg::SYNC_SRC_SW &&
                                     state_reg.sw_sync_n |=> !sync_request)
    else $error("request held with no pin selected");
  restart_count_a: assert property ($rose(link_restart) |-> multiframe_count == 9'h000)
    else $error("link restarted with stale counter");
  restart_pulse_a: assert property (link_restart |=> !link_restart)
    else $error("link restart longer than one cycle");
  enable_restart_a: assert property ($rose(state_reg.link_en) |=> link_restart)
    else $error("link enable rise without restart");
  power_gate_a: assert property (serializer_power_down == !link_clock_enable)
    else $error("serializer power and link clock disagree");

  valid_drop_a: assert property (!sample_valid_in |=> !sample_valid_out)
    else $error("sample valid raised without input valid");
  // With spare low bits, a disabled mark must leave the pad at zero rather than leak the mark input.
  mark_clear_a: assert property (!state_reg.ts_en && (PAD_W > 0) |=> !sample_out[0])
    else $error("pad bit set while timestamp insertion is off");

  se_hold_a: assert property (state_reg.sync_sel == jesd_link_pkg::SYNC_SRC_SE && !state_reg.se_lvl |=>
                              sync_request)
    else $error("low single ended pin did not hold the request");
  td_hold_a: assert property (state_reg.sync_sel == jesd_link_pkg::SYNC_SRC_TD && !state_reg.td_lvl |=>
                              sync_request)
    else $error("low differential pin did not hold the request");

  // A plain frame step: link running and no SYSREF alignment competing in the same cycle.
  logic frame_step;
  assign frame_step = (state_reg.link_state == jesd_link_pkg::LINK_ON) && state_reg.link_en && frame_tick &&
                      !(state_next.sr_lvl && !state_reg.sr_lvl);

  count_step_a: assert property (frame_step && multiframe_count < frames_per_multiframe_last |=>
                                 multiframe_count == $past(multiframe_count) + 9'h001 && !multiframe_boundary)
    else $error("multiframe count did not advance by one");
  count_wrap_a: assert property (frame_step && multiframe_count >= frames_per_multiframe_last |=>
                                 multiframe_count == 9'h000 && multiframe_boundary)
    else $error("multiframe count did not wrap at the last frame");

  // Read data must fall back to zero, so software can never take a stale byte twice.
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data stood longer than one cycle");
  km1_read_a: assert property (rd && addr == jesd_link_pkg::KM1_ADDR |=> rdata == $past(state_reg.km1))
    else $error("frames register read back wrong");
  enable_read_a: assert property (rd && addr == jesd_link_pkg::LINK_EN_ADDR |=>
                                  rdata == {7'h00, $past(state_reg.link_en)})
    else $error("link enable read back wrong");
  sync_read_a: assert property (rd && addr == jesd_link_pkg::SW_SYNC_ADDR |=>
                                rdata == {7'h00, $past(state_reg.sw_sync_n)})
    else $error("sync request bit read back wrong");
  km1_write_a: assert property (wr && addr == jesd_link_pkg::KM1_ADDR |=> state_reg.km1 == $past(wdata))
    else $error("frames register write lost");
  ts_write_a: assert property (wr && addr == jesd_link_pkg::TS_LSB_CTRL_ADDR |=>
                               state_reg.ts_en == $past(wdata[jesd_link_pkg::TS_EN_BIT]))
    else $error("timestamp enable write lost");
  recv_write_a: assert property (wr && addr == jesd_link_pkg::SYNC_SRC_ADDR |=>
                                 timestamp_receiver_enable == $past(wdata[jesd_link_pkg::TS_RECV_BIT]))
    else $error("receiver enable write lost");
  mode_write_a: assert property (wr && addr == jesd_link_pkg::OUT_MODE_ADDR |=>
                                 link_output_mode == $past(wdata[jesd_link_pkg::OUT_MODE_MSB:0]))
    else $error("output mode write lost");

  enable_cycle_c: cover property (!state_reg.link_en ##1 state_reg.link_en ##[1:4] link_restart);
  wrap_c: cover property (multiframe_boundary && state_reg.link_state == jesd_link_pkg::LINK_ON);
  sync_c: cover property ($rose(sync_request) ##[1:20] $fell(sync_request));
  ts_c: cover property (state_reg.ts_en && timestamp_mark && sample_valid_in);

endmodule // jesd_link_control_regs

//--- rtl/jesd_link_pkg.sv
// Register map, field layout, reset values and encodings of the link control registers.
package jesd_link_pkg;

  // Register byte addresses.
  localparam logic [11:0] TS_LSB_CTRL_ADDR  = 12'h160;
  localparam logic [11:0] LINK_EN_ADDR      = 12'h200;
  localparam logic [11:0] OUT_MODE_ADDR     = 12'h201;
  localparam logic [11:0] KM1_ADDR          = 12'h202;
  localparam logic [11:0] SW_SYNC_ADDR      = 12'h203;
  localparam logic [11:0] SYNC_SRC_ADDR     = 12'h210;
  localparam logic [11:0] LINK_STATUS_ADDR  = 12'h211;

  // Field positions.
  localparam int TS_EN_BIT        = 0;
  localparam int LINK_EN_BIT      = 0;
  localparam int OUT_MODE_MSB     = 5;
  localparam int SW_SYNC_BIT      = 0;
  localparam int SYNC_SEL_LSB     = 0;
  localparam int SYNC_SEL_MSB     = 1;
  localparam int TS_RECV_BIT      = 2;
  localparam int STAT_LINK_ON_BIT = 0;
  localparam int STAT_SYNC_BIT    = 1;

  // Reset values.
  localparam logic       TS_EN_RST    = 1'h0;
  localparam logic       LINK_EN_RST  = 1'h1;
  localparam logic [5:0] OUT_MODE_RST = 6'h00;
  localparam logic [7:0] KM1_RST      = 8'h1f;
  localparam logic       SW_SYNC_RST  = 1'h1;
  localparam logic [1:0] SYNC_SEL_RST = 2'h0;
  localparam logic       TS_RECV_RST  = 1'h0;

  // Sync source encodings.
  localparam logic [1:0] SYNC_SRC_SE = 2'h0;
  localparam logic [1:0] SYNC_SRC_TD = 2'h1;
  localparam logic [1:0] SYNC_SRC_SW = 2'h2;

  // Multiplier of E in the effective K of 64B/66B modes.
  localparam logic [16:0] K_64B_MULT = 17'h00100;

  // Control bits per sample advertised in the alignment sequence.
  localparam logic [1:0] ILA_CS_VALUE = 2'h0;

  typedef enum logic [1:0] {
    LINK_OFF = 2'b01,
    LINK_ON  = 2'b10
  } link_state_e;

endpackage

//--- bench/jesd_rx_model.sv
// Far-end receiver model that drives the two sync pins on command from the bench.
`timescale 1ns/100ps
module jesd_rx_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_b,
  // Commands from the bench.
  input  wire logic hold_se_low,
  input  wire logic hold_td_low,
  // Pins towards the device, active low sync.
  output logic      single_ended_sync_pin,
  output logic      timestamp_diff_input
);
  // Both lines are pulled up, so an idle receiver never reads as a request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      single_ended_sync_pin <= 1'h1;
      timestamp_diff_input  <= 1'h1;
    end else begin
      single_ended_sync_pin <= !hold_se_low;
      timestamp_diff_input  <= !hold_td_low;
    end
  end
endmodule // jesd_rx_model

//--- bench/jesd_link_control_regs_tb_top.sv
// Self-checking bench for the link control register bank.
`timescale 1ns/100ps
module jesd_link_control_regs_tb_top;
  logic        clk, rst_b, wr, rd, is_64b, tick, sysref, valid_in, mark, hold_se, hold_td;
  logic        valid_out, link_rst_n, ser_pd, clk_en, restart, sync_req, ts_recv, boundary, se_pin, td_pin;
  logic [11:0] addr, sample_out;
  logic [7:0]  wdata, rdata, mode_e, mode_f;
  logic [8:0]  sample_in, k_last, mf_count;
  logic [5:0]  out_mode;
  logic [1:0]  ila;
  int          mismatches, samples_checked, restarts, boundaries;

  jesd_link_control_regs #(.CONV_W(9), .LINK_W(12)) u_jesd_link_control_regs (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mode_is_64b66b(is_64b), .mode_e(mode_e), .mode_f(mode_f), .frame_tick(tick),
    .single_ended_sync_pin(se_pin), .timestamp_diff_input(td_pin), .sysref_pin(sysref),
    .sample_in(sample_in), .sample_valid_in(valid_in), .timestamp_mark(mark),
    .sample_out(sample_out), .sample_valid_out(valid_out), .link_reset_n(link_rst_n),
    .serializer_power_down(ser_pd), .link_clock_enable(clk_en), .link_restart(restart),
    .sync_request(sync_req), .timestamp_receiver_enable(ts_recv), .link_output_mode(out_mode),
    .frames_per_multiframe_last(k_last), .multiframe_count(mf_count),
    .multiframe_boundary(boundary), .ila_control_bits(ila));

  jesd_rx_model u_jesd_rx_model (
    .clk(clk), .rst_b(rst_b), .hold_se_low(hold_se), .hold_td_low(hold_td),
    .single_ended_sync_pin(se_pin), .timestamp_diff_input(td_pin));

  // Pulses are counted rather than caught, so a check never hangs on one exact cycle.
  always @(posedge clk) begin
    if (restart === 1'h1) restarts++;
    if (boundary === 1'h1) boundaries++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    check(rdata, exp);
  endtask

  task automatic sync_is(input logic exp, input int n);
    cyc(n);
    #1;
    check(sync_req, exp);
  endtask

  task automatic pulse_tick;
    @(posedge clk);
    tick <= 1'h1;
    @(posedge clk);
    tick <= 1'h0;
    cyc(1);
    #1;
  endtask

  // The sysref level is held long enough to pass the input filter.
  task automatic pulse_sysref;
    @(posedge clk);
    sysref <= 1'h1;
    cyc(8);
    sysref <= 1'h0;
    cyc(8);
    #1;
  endtask

  task automatic send(input logic [8:0] s, input logic m, input logic [11:0] exp);
    @(posedge clk);
    sample_in <= s;
    mark      <= m;
    valid_in  <= 1'h1;
    @(posedge clk);
    valid_in <= 1'h0;
    #1;
    check({valid_out, sample_out}, {1'h1, exp});
  endtask

  task automatic t_reset;
    logic [11:0] ra [8] = '{12'h160, 12'h200, 12'h201, 12'h202, 12'h203, 12'h210, 12'h3f0, 12'h211};
    logic [7:0]  rv [8] = '{8'h00, 8'h01, 8'h00, 8'h1f, 8'h01, 8'h00, 8'h00, 8'h01};
    #1;
    check(restarts, 1);
    check({link_rst_n, ser_pd, clk_en, sync_req, ila, k_last}, {4'b1010, 2'h0, 9'h01f});
    reg_wr(12'h3f0, 8'hff);
    for (int i = 0; i < 8; i++) begin
      reg_rd(ra[i], rv[i]);
    end
  endtask

  task automatic t_multiframe;
    int b;
    reg_wr(12'h200, 8'h00);
    reg_wr(12'h202, 8'h01);
    reg_wr(12'h200, 8'h01);
    reg_rd(12'h202, 8'h01);
    cyc(2);
    #1;
    check({restarts[6:0], k_last}, {7'h02, 9'h001});
    b = boundaries;
    pulse_tick;
    check({mf_count, boundaries[6:0]}, {9'h001, 7'(b)});
    pulse_tick;
    check({mf_count, boundaries[6:0]}, {9'h000, 7'(b + 1)});
    pulse_tick;
    pulse_sysref;
    check({mf_count, boundaries[6:0]}, {9'h000, 7'(b + 2)});
  endtask

  task automatic t_disable;
    int b;
    pulse_tick;
    reg_wr(12'h200, 8'h00);
    cyc(2);
    #1;
    check({link_rst_n, ser_pd, clk_en, mf_count}, {3'b010, 9'h000});
    b = boundaries;
    pulse_tick;
    pulse_sysref;
    check({mf_count, boundaries[6:0]}, {9'h000, 7'(b)});
  endtask

  task automatic t_64b;
    reg_wr(12'h201, 8'h2a);
    reg_rd(12'h201, 8'h2a);
    check(out_mode, 6'h2a);
    @(posedge clk);
    is_64b <= 1'h1;
    mode_e <= 8'h03;
    mode_f <= 8'h04;
    reg_wr(12'h200, 8'h01);
    cyc(3);
    #1;
    check(k_last, 9'h0bf);
    @(posedge clk);
    mode_e <= 8'h01;
    mode_f <= 8'h01;
    cyc(2);
    #1;
    check(k_last, 9'h0ff);
    reg_wr(12'h200, 8'h00);
    is_64b <= 1'h0;
    reg_wr(12'h200, 8'h01);
    cyc(3);
    #1;
    check(k_last, 9'h001);
  endtask

  task automatic t_sync;
    reg_wr(12'h203, 8'h00);
    sync_is(1'h1, 2);
    reg_rd(12'h211, 8'h03);
    reg_wr(12'h203, 8'h01);
    sync_is(1'h0, 2);
    @(posedge clk);
    hold_se <= 1'h1;
    sync_is(1'h1, 8);
    reg_wr(12'h203, 8'h01);
    sync_is(1'h1, 2);
    reg_wr(12'h210, 8'h02);
    sync_is(1'h0, 3);
    reg_wr(12'h203, 8'h00);
    sync_is(1'h1, 2);
    reg_wr(12'h203, 8'h01);
    hold_se <= 1'h0;
    reg_wr(12'h210, 8'h05);
    hold_td <= 1'h1;
    sync_is(1'h1, 8);
    reg_wr(12'h203, 8'h00);
    hold_td <= 1'h0;
    sync_is(1'h1, 8);
    reg_wr(12'h203, 8'h01);
    sync_is(1'h0, 2);
    reg_wr(12'h210, 8'h00);
  endtask

  task automatic t_timestamp;
    reg_wr(12'h160, 8'h01);
    reg_wr(12'h210, 8'h04);
    reg_rd(12'h160, 8'h01);
    check({ts_recv, ila}, 3'b100);
    send(9'h1ff, 1'h1, 12'hff9);
    send(9'h001, 1'h0, 12'h008);
    send(9'h001, 1'h1, 12'h009);
    reg_wr(12'h160, 8'h00);
    send(9'h0aa, 1'h1, 12'h550);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    {rst_b, wr, rd, is_64b, tick, sysref, valid_in, mark, hold_se, hold_td} = '0;
    {addr, wdata, sample_in, mode_e, mode_f} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    cyc(2);
    t_reset;
    t_multiframe;
    t_disable;
    t_64b;
    t_sync;
    t_timestamp;
    wrap_up;
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #40000;
    mismatches++;
    wrap_up;
  end
endmodule // jesd_link_control_regs_tb_top
